// File: dv/twt_host_model.sv
// Host side of the three-wire bus: frame select, bus clock and data pins.
// Assumes the bench calls its tasks; steps land on falling edges of the system clock.
`timescale 1ns/10ps
module twt_host_model (
  // System clock used only for alignment
  input  wire logic clk_sys_in,
  // Bus pins towards the device
  output logic      bus_en_out,
  output logic      bus_clk_out,
  output logic      bus_data_out
);
  // ************************************************************
  // Idle levels
  // ************************************************************
  initial begin
    bus_en_out   = 1'b0;
    bus_clk_out  = 1'b0;
    bus_data_out = 1'b0;
  end

  // ************************************************************
  // One frame, n bits taken from word, bit 0 first
  // ************************************************************
  task automatic send(input int unsigned n, input logic [31:0] word);
    int unsigned i;
    @(negedge clk_sys_in);
    bus_en_out = 1'b1;
    #100;
    for (i = 0; i < n; i++) begin
      bus_data_out = word[i];
      #100;
      bus_clk_out = 1'b1;
      #100;
      bus_clk_out = 1'b0;
    end
    #100;
    bus_en_out   = 1'b0;
    bus_data_out = ~bus_data_out;
  endtask : send

  // ************************************************************
  // Bus clock pulses with frame select low
  // ************************************************************
  task automatic stray(input int unsigned n);
    int unsigned i;
    @(negedge clk_sys_in);
    for (i = 0; i < n; i++) begin
      bus_data_out = ~bus_data_out;
      #100;
      bus_clk_out = 1'b1;
      #100;
      bus_clk_out = 1'b0;
    end
  endtask : stray
endmodule : twt_host_model

// File: dv/twt_tb.sv
// Self-checking bench for the three-wire trim control block.
// Assumes the host model drives the pins; expected results queue up per frame.
`timescale 1ns/10ps
module testbench;
  import twt_pkg::*;

  // ************************************************************
  // Signals
  // ************************************************************
  logic          clk;
  logic          rst;
  wire logic     bus_en;
  wire logic     bus_clk;
  wire logic     bus_data;
  logic [7:0]    t1g;
  logic [7:0]    t2g;
  logic [5:0]    t1o;
  logic [5:0]    t2o;
  logic          refsel;
  logic [2:0]    lvl;
  logic [3:0]    sw;
  logic [3:0]    sw_oe_n;
  logic [6:0]    xcap;
  logic          xfix_n;
  logic [21:0]   w_ref;
  logic [21:0]   w_main;
  logic [21:0]   w_xtal;
  logic          done;
  logic          rej;
  logic [13:0]   r16 [0:1];
  logic [21:0]   r24 [0:2];
  logic [115:0]  q [$];
  logic [115:0]  cur;
  int            err_total;
  int            total_checks;
  int            cycles;
  integer        seed = 32'hc905b033;
  wire  [115:0]  obs = {t1g, t1o, t2g, t2o, refsel, lvl, sw, sw_oe_n, xcap, xfix_n,
                        w_ref, w_main, w_xtal, done, rej};

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  twt_host_model twt_host_model_i (
    .clk_sys_in   (clk),
    .bus_en_out   (bus_en),
    .bus_clk_out  (bus_clk),
    .bus_data_out (bus_data)
  );

  twt_trim_ctrl twt_trim_ctrl_i (
    .clk_sys_in            (clk),
    .rst_in                (rst),
    .bus_en_in             (bus_en),
    .bus_clk_in            (bus_clk),
    .bus_data_in           (bus_data),
    .trim1_gain_out        (t1g),
    .trim1_offset_out      (t1o),
    .trim2_gain_out        (t2g),
    .trim2_offset_out      (t2o),
    .trim_ref_fixed_out    (refsel),
    .level_code_out        (lvl),
    .switch_out_out        (sw),
    .switch_out_oe_n_out   (sw_oe_n),
    .xtal_cap_inv_code_out (xcap),
    .xtal_fixed_add_n_out  (xfix_n),
    .refdiv_word_out       (w_ref),
    .main_word_out         (w_main),
    .xtal_word_out         (w_xtal),
    .cmd_done_out          (done),
    .cmd_reject_out        (rej)
  );

  // ************************************************************
  // Expected outputs from the register images
  // ************************************************************
  function automatic logic [115:0] exp_vec(input logic d, input logic r);
    return {r16[0][7:0], r16[0][13:8], r16[1][7:0], r16[1][13:8], r24[1][20],
            r24[0][18:16], 4'h0, r24[1][19:16], r24[2][10:4], r24[2][11],
            r24[0], r24[1], r24[2], d, r};
  endfunction : exp_vec

  task automatic check(input logic [115:0] seen, input logic [115:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t outputs %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // ************************************************************
  // Monitor: status pulse takes the oldest note
  // ************************************************************
  always @(negedge clk) begin
    if (rst === 1'b0) begin
      if ((done | rej) === 1'b1) begin
        if (q.size() == 0) begin
          err_total++;
          $display("BAD %0t status pulse with no frame", $time);
        end else begin
          check(obs, q[0]);
          cur = q.pop_front();
          cur[1:0] = 2'b00;
        end
      end else if (obs !== cur) begin
        check(obs, cur);
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      $display("BAD %0t run too long", $time);
      test_done();
    end
  end

  // ************************************************************
  // Driver tasks
  // ************************************************************
  task automatic do_reset(input int n);
    @(negedge clk);
    rst = 1'b1;
    repeat (n) @(negedge clk);
    r16 = '{RST_BODY16, RST_BODY16};
    r24 = '{RST_REFDIV, RST_MAIN, RST_XTAL};
    cur = exp_vec(1'b0, 1'b0);
    rst = 1'b0;
    check(obs, cur);
    repeat (3) @(negedge clk);
  endtask : do_reset

  task automatic cmd(input int unsigned n, input logic [31:0] w, input logic ok);
    int k;
    if (ok && n == CMD_SHORT_LEN)
      r16[w[14]] = w[13:0];
    else if (ok)
      r24[w[23:22]] = w[21:0];
    q.push_back(exp_vec(ok, !ok));
    twt_host_model_i.send(n, w);
    for (k = 0; k < 12 && q.size() != 0; k++)
      @(negedge clk);
    if (q.size() != 0) begin
      err_total++;
      $display("BAD %0t no status pulse", $time);
      q.delete();
    end
  endtask : cmd

  task automatic writes(input int n);
    int i;
    logic [31:0] rnd;
    for (i = 0; i < n; i++) begin
      rnd = $random(seed);
      rnd[20] = ((i / 5) % 2) != 0;
      case (i % 5)
        0: cmd(16, {16'h0, ADR16_TRIM1, rnd[13:0]}, 1'b1);
        1: cmd(16, {16'h0, ADR16_TRIM2, rnd[13:0]}, 1'b1);
        2: cmd(24, {8'h0, ADR24_REFDIV, rnd[21:0]}, 1'b1);
        3: cmd(24, {8'h0, ADR24_MAIN, rnd[21:0]}, 1'b1);
        default: cmd(24, {8'h0, ADR24_XTAL, rnd[21:0]}, 1'b1);
      endcase
    end
  endtask : writes

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    int unsigned bad_n [0:6];
    logic [1:0]  bad_a [0:6];
    logic [31:0] w;
    int          j;
    bad_n = '{15, 17, 23, 25, 16, 16, 24};
    bad_a = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    rst = 1'b1;
    cur = '0;
    do_reset(15);
    writes(20);
    twt_host_model_i.stray(6);
    repeat (20) @(negedge clk);
    check(obs, cur);
    for (j = 0; j < 7; j++) begin
      w = $random(seed);
      if (bad_n[j] == 16)
        w[15:14] = bad_a[j];
      if (bad_n[j] == 24)
        w[23:22] = bad_a[j];
      cmd(bad_n[j], w, 1'b0);
    end
    writes(5);
    do_reset(4);
    writes(10);
    test_done();
  end
endmodule : testbench

// File: verilog/twt_link_if.sv
// Carrier between the pin front end and the command decoder.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
interface twt_link_if;
  logic open_stb;
  logic close_stb;
  logic bit_stb;
  logic bit_val;

  modport front (output open_stb, output close_stb, output bit_stb, output bit_val);
  modport core  (input  open_stb, input  close_stb, input  bit_stb, input  bit_val);
endinterface : twt_link_if

// File: verilog/twt_pin_front.sv
// Synchronises the three bus pins and finds the enable and bus clock edges.
// Assumes pins are asynchronous to clk_sys_in and much slower.
`timescale 1ns/10ps
module twt_pin_front (
  // Clock and reset
  input  wire logic    clk_sys_in,
  input  wire logic    rst_in,
  // Bus pins
  input  wire logic    bus_en_in,
  input  wire logic    bus_clk_in,
  input  wire logic    bus_data_in,
  // Decoded events
  twt_link_if.front    lnk
);

  logic [2:0] meta;
  logic [2:0] sync;
  logic [1:0] last;
  wire        en_rise;
  wire        en_fall;
  wire        ck_rise;

  // ************************************************************
  // Two-stage synchronisers, edge history
  // ************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      meta <= 3'h0;
      sync <= 3'h0;
      last <= 2'h0;
    end else begin
      meta <= {bus_data_in, bus_clk_in, bus_en_in};
      sync <= meta;
      last <= sync[1:0];
    end
  end

  assign en_rise = sync[0] & ~last[0];
  assign en_fall = ~sync[0] & last[0];
  assign ck_rise = sync[1] & ~last[1] & sync[0];

  // ************************************************************
  // Registered event pulses
  // ************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      lnk.open_stb  <= 1'b0;
      lnk.close_stb <= 1'b0;
      lnk.bit_stb   <= 1'b0;
      lnk.bit_val   <= 1'b0;
    end else begin
      lnk.open_stb  <= en_rise;
      lnk.close_stb <= en_fall;
      lnk.bit_stb   <= ck_rise;
      lnk.bit_val   <= sync[2];
    end
  end

endmodule : twt_pin_front

// File: verilog/twt_pkg.sv
// Constants for the three-wire trim control block.
// Assumes commands arrive least significant bit first on a three-wire bus.
package twt_pkg;

  // ************************************************************
  // Command framing
  // ************************************************************
  localparam int         CMD_SHORT_LEN = 16;
  localparam int         CMD_LONG_LEN  = 24;
  localparam int         CNT_W         = 5;
  localparam logic [4:0] CNT_SHORT     = 5'h10;
  localparam logic [4:0] CNT_LONG      = 5'h18;
  localparam logic [4:0] CNT_SAT       = 5'h1f;
  localparam int         SHIFT_W       = 24;

  // ************************************************************
  // Address codes, unique per command length
  // ************************************************************
  localparam logic [1:0] ADR16_TRIM1  = 2'h0;
  localparam logic [1:0] ADR16_TRIM2  = 2'h1;
  localparam logic [1:0] ADR24_REFDIV = 2'h0;
  localparam logic [1:0] ADR24_MAIN   = 2'h1;
  localparam logic [1:0] ADR24_XTAL   = 2'h2;
  localparam int         ADR16_LSB    = 14;
  localparam int         ADR24_LSB    = 22;

  // ************************************************************
  // Register bodies and field positions
  // ************************************************************
  localparam int BODY16_W  = 14;
  localparam int BODY24_W  = 22;
  localparam int GAIN_LSB  = 0;
  localparam int GAIN_W    = 8;
  localparam int OFS_LSB   = 8;
  localparam int OFS_W     = 6;
  localparam int LVL_LSB   = 16;
  localparam int LVL_W     = 3;
  localparam int SW_LSB    = 16;
  localparam int SW_N      = 4;
  localparam int MODE_BIT  = 20;
  localparam int XCAP_LSB  = 4;
  localparam int XCAP_W    = 7;
  localparam int XFIX_BIT  = 11;

  // Internal fixed trim reference in AM mode, millivolts
  localparam int TRIM_REF_MV = 3000;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [13:0] RST_BODY16 = 14'h0000;
  localparam logic [21:0] RST_REFDIV = 22'h000000;
  localparam logic [21:0] RST_MAIN   = 22'h0f0000;
  localparam logic [21:0] RST_XTAL   = 22'h000ff0;

  typedef enum logic [0:0] {
    TWT_IDLE  = 1'b0,
    TWT_SHIFT = 1'b1
  } twt_state_t;

endpackage : twt_pkg

// File: verilog/twt_trim_ctrl.sv
// Three-wire write port and control field decoder of a tuning synthesizer.
// Assumes bus pins are asynchronous and a bus clock period of many sysclks.
`timescale 1ns/10ps

// Behaviour
// - AM mode swaps both trim converter inputs to the fixed 3V reference.
// - First trim gain is bits B36..B43, rising 256-step code.
// - Second trim gain is bits B0..B7, same mapping.
// - First trim offset is bits B44..B49, code 0 most positive.
// - Second trim offset is bits B8..B13, same descending mapping.
// - Level converter code is bits B66..B68, monotonic rising levels.
// - Switch X+1 follows B30+X; 0 pulls to ground, 1 releases.
// - Crystal capacitance from B78..B85, inverted code, B85 low adds 8 pF.
// - Every setting is written only through the three-wire bus.
// - One command replaces all bits of exactly one register.
// - Target register chosen by command length plus two address bits.
// - Sixteen-bit registers take 16-bit commands, 24-bit take 24-bit.
// - Command opens on enable rising and closes on enable falling.
// - Bits run from LSB of first byte to MSB of last byte.
// - Data is sampled on each rising bus clock edge.
// - Rising clock edges during enable high give the command length.
// - Length plus address scheme lets companion chips share the bus.
// - Mode bit B34: 0 FM tuning voltage, 1 AM fixed reference.
module twt_trim_ctrl
  import twt_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys_in,
  input  wire logic                rst_in,
  // Three-wire bus pins
  input  wire logic                bus_en_in,
  input  wire logic                bus_clk_in,
  input  wire logic                bus_data_in,
  // Trim converters
  output logic [GAIN_W-1:0]        trim1_gain_out,
  output logic [OFS_W-1:0]         trim1_offset_out,
  output logic [GAIN_W-1:0]        trim2_gain_out,
  output logic [OFS_W-1:0]         trim2_offset_out,
  output logic                     trim_ref_fixed_out,
  // Level converter
  output logic [LVL_W-1:0]         level_code_out,
  // Open-drain switch outputs
  output logic [SW_N-1:0]          switch_out_out,
  output logic [SW_N-1:0]          switch_out_oe_n_out,
  // Crystal tuning
  output logic [XCAP_W-1:0]        xtal_cap_inv_code_out,
  output logic                     xtal_fixed_add_n_out,
  // Raw 24-bit register bodies for the PLL side
  output logic [BODY24_W-1:0]      refdiv_word_out,
  output logic [BODY24_W-1:0]      main_word_out,
  output logic [BODY24_W-1:0]      xtal_word_out,
  // Command status
  output logic                     cmd_done_out,
  output logic                     cmd_reject_out
);

  // ************************************************************
  // Pin front end
  // ************************************************************
  twt_link_if lnk ();

  twt_pin_front u_front (
    .clk_sys_in  (clk_sys_in),
    .rst_in      (rst_in),
    .bus_en_in   (bus_en_in),
    .bus_clk_in  (bus_clk_in),
    .bus_data_in (bus_data_in),
    .lnk         (lnk)
  );

  // ************************************************************
  // Frame state, bit count, shift store
  // ************************************************************
  twt_state_t         state;
  twt_state_t         next_state;
  logic [CNT_W-1:0]   cnt;
  logic [SHIFT_W-1:0] sh;
  logic [BODY16_W-1:0] reg_trim1;
  logic [BODY16_W-1:0] reg_trim2;
  logic [BODY24_W-1:0] reg_refdiv;
  logic [BODY24_W-1:0] reg_main;
  logic [BODY24_W-1:0] reg_xtal;

  wire in_frame  = (state == TWT_SHIFT);
  wire take_bit  = in_frame & lnk.bit_stb;
  wire close_ev  = in_frame & lnk.close_stb;
  wire cnt_full  = (cnt == CNT_SAT);
  wire len16     = (cnt == CNT_SHORT);
  wire len24     = (cnt == CNT_LONG);
  wire [1:0] adr16 = sh[ADR16_LSB +: 2];
  wire [1:0] adr24 = sh[ADR24_LSB +: 2];

  // Register select by length and address
  wire wr_trim1  = close_ev & len16 & (adr16 == ADR16_TRIM1);
  wire wr_trim2  = close_ev & len16 & (adr16 == ADR16_TRIM2);
  wire wr_refdiv = close_ev & len24 & (adr24 == ADR24_REFDIV);
  wire wr_main   = close_ev & len24 & (adr24 == ADR24_MAIN);
  wire wr_xtal   = close_ev & len24 & (adr24 == ADR24_XTAL);
  wire wr_any    = wr_trim1 | wr_trim2 | wr_refdiv | wr_main | wr_xtal;

  // Frame opens on enable rise, closes on fall
  always_comb begin
    next_state = state;
    unique case (state)
      TWT_IDLE:  if (lnk.open_stb) begin
        next_state = TWT_SHIFT;
      end
      TWT_SHIFT: if (lnk.close_stb) begin
        next_state = TWT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= TWT_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Count rising clock edges, saturating
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt <= 5'h00;
    end else if (lnk.open_stb) begin
      cnt <= 5'h00;
    end else if (take_bit && !cnt_full) begin
      cnt <= cnt + 5'h01;
    end
  end

  // First bit lands at position 0
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sh <= 24'h000000;
    end else if (lnk.open_stb) begin
      sh <= 24'h000000;
    end else if (take_bit && cnt < CNT_LONG) begin
      sh[cnt] <= lnk.bit_val;
    end
  end

  // ************************************************************
  // Register loads at frame close only
  // ************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_trim1  <= RST_BODY16;
      reg_trim2  <= RST_BODY16;
      reg_refdiv <= RST_REFDIV;
      reg_main   <= RST_MAIN;
      reg_xtal   <= RST_XTAL;
    end else begin
      if (wr_trim1) begin
        reg_trim1 <= sh[BODY16_W-1:0];
      end
      if (wr_trim2) begin
        reg_trim2 <= sh[BODY16_W-1:0];
      end
      if (wr_refdiv) begin
        reg_refdiv <= sh[BODY24_W-1:0];
      end
      if (wr_main) begin
        reg_main <= sh[BODY24_W-1:0];
      end
      if (wr_xtal) begin
        reg_xtal <= sh[BODY24_W-1:0];
      end
    end
  end

  // Command outcome pulses
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cmd_done_out   <= 1'b0;
      cmd_reject_out <= 1'b0;
    end else begin
      cmd_done_out   <= wr_any;
      cmd_reject_out <= close_ev & ~wr_any;
    end
  end

  // Open-drain low level held in a flop
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      switch_out_out <= 4'h0;
    end else begin
      switch_out_out <= 4'h0;
    end
  end

  // ************************************************************
  // Field outputs, straight from the register flops
  // ************************************************************
  assign trim1_gain_out        = reg_trim1[GAIN_LSB +: GAIN_W];
  assign trim1_offset_out      = reg_trim1[OFS_LSB +: OFS_W];
  assign trim2_gain_out        = reg_trim2[GAIN_LSB +: GAIN_W];
  assign trim2_offset_out      = reg_trim2[OFS_LSB +: OFS_W];
  assign trim_ref_fixed_out    = reg_main[MODE_BIT];
  assign level_code_out        = reg_refdiv[LVL_LSB +: LVL_W];
  assign switch_out_oe_n_out   = reg_main[SW_LSB +: SW_N];
  assign xtal_cap_inv_code_out = reg_xtal[XCAP_LSB +: XCAP_W];
  assign xtal_fixed_add_n_out  = reg_xtal[XFIX_BIT];
  assign refdiv_word_out       = reg_refdiv;
  assign main_word_out         = reg_main;
  assign xtal_word_out         = reg_xtal;

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_main_load;
    wr_main;
  endsequence

  sequence s_bad_close;
    close_ev && !len16 && !len24;
  endsequence

  property p_ref_am;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_main_load and sh[MODE_BIT] |=> trim_ref_fixed_out;
  endproperty
  a_ref_am: assert property (p_ref_am)
    else $error("AM mode did not select fixed reference");

  property p_ref_fm;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_main_load and !sh[MODE_BIT] |=> !trim_ref_fixed_out;
  endproperty
  a_ref_fm: assert property (p_ref_fm)
    else $error("FM mode did not select tuning voltage");

  property p_gain1;
    @(posedge clk_sys_in) disable iff (rst_in)
      wr_trim1 |=> trim1_gain_out == $past(sh[7:0]);
  endproperty
  a_gain1: assert property (p_gain1)
    else $error("first gain not loaded");

  property p_gain2;
    @(posedge clk_sys_in) disable iff (rst_in)
      wr_trim2 |=> trim2_gain_out == $past(sh[7:0]);
  endproperty
  a_gain2: assert property (p_gain2)
    else $error("second gain not loaded");

  property p_ofs1;
    @(posedge clk_sys_in) disable iff (rst_in)
      wr_trim1 |=> trim1_offset_out == $past(sh[13:8]);
  endproperty
  a_ofs1: assert property (p_ofs1)
    else $error("first offset not loaded");

  property p_ofs2;
    @(posedge clk_sys_in) disable iff (rst_in)
      wr_trim2 |=> trim2_offset_out == $past(sh[13:8]);
  endproperty
  a_ofs2: assert property (p_ofs2)
    else $error("second offset not loaded");

  property p_level;
    @(posedge clk_sys_in) disable iff (rst_in)
      wr_refdiv |=> level_code_out == $past(sh[18:16]);
  endproperty
  a_level: assert property (p_level)
    else $error("level code not loaded");

  property p_switch;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_main_load |=> switch_out_oe_n_out == $past(sh[19:16]) && switch_out_out == 4'h0;
  endproperty
  a_switch: assert property (p_switch)
    else $error("switch drive wrong");

  property p_xtal;
    @(posedge clk_sys_in) disable iff (rst_in)
      wr_xtal |=> {xtal_fixed_add_n_out, xtal_cap_inv_code_out} == $past(sh[11:4]);
  endproperty
  a_xtal: assert property (p_xtal)
    else $error("crystal tuning not loaded");

  property p_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
      !close_ev |=> $stable(reg_trim1) && $stable(reg_trim2) && $stable(reg_main)
                    && $stable(reg_refdiv) && $stable(reg_xtal);
  endproperty
  a_hold: assert property (p_hold)
    else $error("register changed outside frame close");

  property p_bad_len;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_bad_close |=> $stable(reg_refdiv) && $stable(reg_xtal) && cmd_reject_out;
  endproperty
  a_bad_len: assert property (p_bad_len)
    else $error("bad length command changed state");

  property p_count;
    @(posedge clk_sys_in) disable iff (rst_in)
      take_bit && !cnt_full && !lnk.open_stb |=> cnt == $past(cnt) + 5'h01;
  endproperty
  a_count: assert property (p_count)
    else $error("edge count did not advance");

  property p_frame;
    @(posedge clk_sys_in) disable iff (rst_in)
      close_ev |=> (state == TWT_IDLE) && (cmd_done_out != cmd_reject_out);
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame did not close");

  sequence s_open;
    (state == TWT_IDLE) && lnk.open_stb;
  endsequence

  property p_open;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_open |=> in_frame && (cnt == 5'h00) && (sh == 24'h000000);
  endproperty
  a_open: assert property (p_open)
    else $error("frame did not open cleanly");

  property p_take;
    @(posedge clk_sys_in) disable iff (rst_in)
      take_bit && (cnt < CNT_LONG) |=> sh[$past(cnt)] == $past(lnk.bit_val);
  endproperty
  a_take: assert property (p_take)
    else $error("sampled bit not stored at its position");

  property p_bad_adr16;
    @(posedge clk_sys_in) disable iff (rst_in)
      close_ev && len16 && adr16[1] |=> cmd_reject_out && !cmd_done_out;
  endproperty
  a_bad_adr16: assert property (p_bad_adr16)
    else $error("unused short address was accepted");

  property p_bad_adr24;
    @(posedge clk_sys_in) disable iff (rst_in)
      close_ev && len24 && (adr24 == 2'h3) |=> cmd_reject_out && !cmd_done_out;
  endproperty
  a_bad_adr24: assert property (p_bad_adr24)
    else $error("unused long address was accepted");

  property p_pulse;
    @(posedge clk_sys_in) disable iff (rst_in)
      wr_any |=> cmd_done_out && !cmd_reject_out ##1 !cmd_done_out;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("load pulse wrong");

endmodule : twt_trim_ctrl
